// File: verilog/lkdet_map.vh
// Widths, reset values and state codes for the digital lock detector
`ifndef LKDET_MAP_VH
`define LKDET_MAP_VH

// Edge timing error and window setting width
`define LKDET_ERR_W 8
// Qualifying-cycle counter and lock count width
`define LKDET_CNT_W 14
// Number of loops watched: index 0 outer, index 1 inner
`define LKDET_LOOPS 2
`define LKDET_OUTER 0
`define LKDET_INNER 1

// Reset values, counter maximum and increment, and bit set value
`define LKDET_CNT_RST 14'h0000
`define LKDET_CNT_MAX 14'h3FFF
`define LKDET_CNT_ONE 14'h0001
`define LKDET_BIT_RST 1'h0
`define LKDET_BIT_SET 1'h1

// Holdover exit selection value meaning exit on lock event
`define LKDET_EXIT_ON_LOCK 1'h1

// Holdover state codes
`define LKDET_ST_W 1
`define LKDET_ST_RUN 1'h0
`define LKDET_ST_HOLD 1'h1

`endif

// File: verilog/lkdet_qual_counter.v
// Per-loop qualifying-cycle counter and lock indication
`timescale 1ns/100ps
`default_nettype none
`include "lkdet_map.vh"

module lkdet_qual_counter (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Phase-detector sample
  input wire pd_strobe,
  input wire [`LKDET_ERR_W-1:0] edge_err,
  // Settings of this loop
  input wire [`LKDET_ERR_W-1:0] window_width,
  input wire [`LKDET_CNT_W-1:0] lock_count,
  // Results
  output reg [`LKDET_CNT_W-1:0] qual_count_reg,
  output reg in_window_reg,
  output reg lock_flag_reg
);

  wire in_window;
  wire [`LKDET_CNT_W-1:0] qual_count_next;

  assign in_window = (edge_err <= window_width); // [RULE_02]
  // Saturate so a long lock never wraps back below the lock count
  assign qual_count_next = (qual_count_reg == `LKDET_CNT_MAX) ?
    qual_count_reg : qual_count_reg + `LKDET_CNT_ONE; // [RULE_02]

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      qual_count_reg <= `LKDET_CNT_RST;
      in_window_reg <= `LKDET_BIT_RST;
      lock_flag_reg <= `LKDET_BIT_RST;
    end else if (pd_strobe) begin
      if (in_window) begin
        qual_count_reg <= qual_count_next; // [RULE_02]
        in_window_reg <= `LKDET_BIT_SET;
        lock_flag_reg <= (qual_count_next >= lock_count); // [RULE_01]
      end else begin
        qual_count_reg <= `LKDET_CNT_RST; // [RULE_03]
        in_window_reg <= `LKDET_BIT_RST;
        lock_flag_reg <= `LKDET_BIT_RST; // [RULE_10]
      end
    end
  end

endmodule // lkdet_qual_counter
`default_nettype wire

// File: verilog/lkdet_top.v
// Digital lock detector for the outer and inner loops with holdover exit
`timescale 1ns/100ps
`default_nettype none
`include "lkdet_map.vh"

////////////////////////////////////////////////////////////////////////////
// What this block does
// RULE_01 - Lock asserts when qualifying count reaches lock count
// RULE_02 - Count phase-detector cycles with error inside window
// RULE_03 - Out-of-window edge clears the count to zero
// RULE_04 - Outer loop uses its own window and count
// RULE_05 - Inner loop uses its own independent settings
// RULE_06 - Holdover exit: outer window, separate lock count
// RULE_07 - Exit-on-lock selected: leave holdover on that event
// RULE_08 - Lost flag sets on each falling lock edge while the clear bit is low
// RULE_09 - Clear bit high holds the lost flag zero
// RULE_10 - Lock drops in the cycle the count clears
module lkdet_top (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Outer loop phase-detector samples
  input wire outer_pd_strobe,
  input wire [`LKDET_ERR_W-1:0] outer_edge_err,
  // Inner loop phase-detector samples
  input wire inner_pd_strobe,
  input wire [`LKDET_ERR_W-1:0] inner_edge_err,
  // Outer loop settings
  input wire [`LKDET_ERR_W-1:0] outer_loop_window_width,
  input wire [`LKDET_CNT_W-1:0] outer_loop_lock_count,
  // Inner loop settings
  input wire [`LKDET_ERR_W-1:0] inner_loop_window_width,
  input wire [`LKDET_CNT_W-1:0] inner_loop_lock_count,
  // Holdover control
  input wire [`LKDET_CNT_W-1:0] hold_release_lock_count,
  input wire hold_exit_on_lock,
  input wire holdover_enter,
  // Lost-flag clears
  input wire outer_loop_lost_clear,
  input wire inner_loop_lost_clear,
  // Lock indications
  output wire outer_loop_lock_flag,
  output wire inner_loop_lock_flag,
  // Sticky lock-lost flags
  output wire outer_loop_lock_lost_flag,
  output wire inner_loop_lock_lost_flag,
  // Holdover status
  output reg holdover_active_reg,
  output reg hold_release_pulse_reg
);

  ////////////////////////////////////////////////////////////////////////////
  // Per-loop input bundling

  wire [`LKDET_LOOPS-1:0] pd_strobe;
  wire [`LKDET_LOOPS*`LKDET_ERR_W-1:0] edge_err;
  wire [`LKDET_LOOPS*`LKDET_ERR_W-1:0] window_width;
  wire [`LKDET_LOOPS*`LKDET_CNT_W-1:0] lock_count;
  wire [`LKDET_LOOPS-1:0] lost_clear;
  // Only the outer count and window flag feed the holdover logic
  wire [`LKDET_LOOPS*`LKDET_CNT_W-1:0] qual_count;
  wire [`LKDET_LOOPS-1:0] in_window;
  wire [`LKDET_LOOPS-1:0] lock_flag;
  wire [`LKDET_LOOPS-1:0] lost_flag;

  // Index 0 is the outer loop, index 1 the inner loop
  assign pd_strobe = {inner_pd_strobe, outer_pd_strobe};
  assign edge_err = {inner_edge_err, outer_edge_err};
  assign window_width = {inner_loop_window_width,
    outer_loop_window_width}; // [RULE_04] [RULE_05]
  assign lock_count = {inner_loop_lock_count,
    outer_loop_lock_count}; // [RULE_04] [RULE_05]
  assign lost_clear = {inner_loop_lost_clear, outer_loop_lost_clear};

  ////////////////////////////////////////////////////////////////////////////
  // Per-loop detection and lost flags

  genvar gi;
  generate
    for (gi = 0; gi < `LKDET_LOOPS; gi = gi + 1) begin : g_loop
      reg lock_prev_reg;
      reg lost_flag_reg;
      reg lost_flag_next;
      wire lock_fell;

      // Counter, window flag and lock indication of this loop
      lkdet_qual_counter u_counter (
        .clk(clk),
        .rstn(rstn),
        .pd_strobe(pd_strobe[gi]),
        .edge_err(edge_err[gi*`LKDET_ERR_W +: `LKDET_ERR_W]),
        .window_width(window_width[gi*`LKDET_ERR_W +: `LKDET_ERR_W]),
        .lock_count(lock_count[gi*`LKDET_CNT_W +: `LKDET_CNT_W]),
        .qual_count_reg(qual_count[gi*`LKDET_CNT_W +: `LKDET_CNT_W]),
        .in_window_reg(in_window[gi]),
        .lock_flag_reg(lock_flag[gi])
      );

      // Only a true high-to-low transition counts, so clearing while
      // already unlocked does not re-set the flag
      assign lock_fell = lock_prev_reg & ~lock_flag[gi]; // [RULE_08]

      // Resets low like the indication, so no false fall after reset
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          lock_prev_reg <= `LKDET_BIT_RST;
        end else begin
          lock_prev_reg <= lock_flag[gi];
        end
      end

      // Clear held high overrides a coincident falling edge
      always @* begin
        lost_flag_next = lost_flag_reg;
        if (lost_clear[gi]) begin
          lost_flag_next = `LKDET_BIT_RST; // [RULE_09]
        end else if (lock_fell) begin
          lost_flag_next = `LKDET_BIT_SET; // [RULE_08]
        end
      end

      // Sticky until software clears it
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          lost_flag_reg <= `LKDET_BIT_RST;
        end else begin
          lost_flag_reg <= lost_flag_next;
        end
      end

      assign lost_flag[gi] = lost_flag_reg;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Status outputs, each straight from its flip-flop

  // Lock indications
  assign outer_loop_lock_flag = lock_flag[`LKDET_OUTER];
  assign inner_loop_lock_flag = lock_flag[`LKDET_INNER];

  // Sticky lost flags
  assign outer_loop_lock_lost_flag = lost_flag[`LKDET_OUTER];
  assign inner_loop_lock_lost_flag = lost_flag[`LKDET_INNER];

  ////////////////////////////////////////////////////////////////////////////
  // Holdover exit event

  localparam ST_RUN = `LKDET_ST_RUN;
  localparam ST_HOLD = `LKDET_ST_HOLD;

  wire [`LKDET_CNT_W-1:0] outer_count;
  wire hold_count_met;
  wire hold_hit;
  wire hold_exit_sel;
  wire hold_rise;
  reg hold_hit_prev_reg;
  reg [`LKDET_ST_W-1:0] state_reg;
  reg [`LKDET_ST_W-1:0] state_next;

  assign outer_count = qual_count[`LKDET_OUTER*`LKDET_CNT_W +: `LKDET_CNT_W];
  // Shares the outer counter, hence the outer window, but its own count
  assign hold_count_met =
    (outer_count >= hold_release_lock_count); // [RULE_06]
  // The window flag keeps a zero count setting from firing before any
  // in-window sample
  assign hold_hit = in_window[`LKDET_OUTER] & hold_count_met; // [RULE_06]
  assign hold_exit_sel = (hold_exit_on_lock == `LKDET_EXIT_ON_LOCK);
  // Release pulse marks the exit event in either exit mode
  assign hold_rise = hold_hit & ~hold_hit_prev_reg; // [RULE_06]

  ////////////////////////////////////////////////////////////////////////////
  // Holdover state: entered on request, left on the exit event

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (holdover_enter) begin
          state_next = ST_HOLD;
        end else begin
          state_next = ST_RUN;
        end
      end
      ST_HOLD: begin
        // Without exit-on-lock only reset leaves holdover
        if (hold_exit_sel && hold_hit) begin
          state_next = ST_RUN; // [RULE_07]
        end else begin
          state_next = ST_HOLD;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_RUN;
      holdover_active_reg <= `LKDET_BIT_RST;
    end else begin
      state_reg <= state_next;
      // Mirrors the next state, so the status adds no lag
      holdover_active_reg <= (state_next == ST_HOLD);
    end
  end

  // Edge detector on the exit condition
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hold_hit_prev_reg <= `LKDET_BIT_RST;
      hold_release_pulse_reg <= `LKDET_BIT_RST;
    end else begin
      hold_hit_prev_reg <= hold_hit;
      hold_release_pulse_reg <= hold_rise; // [RULE_06]
    end
  end

endmodule // lkdet_top
`default_nettype wire

// File: testbench/lkdet_top_sva.sv
// Assertion checker for the lock detector top ports
`timescale 1ns/100ps
`default_nettype none
module lkdet_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Outer loop and holdover inputs
  input wire logic outer_pd_strobe,
  input wire logic [7:0] outer_edge_err,
  input wire logic [7:0] outer_loop_window_width,
  input wire logic hold_exit_on_lock,
  input wire logic outer_loop_lost_clear,
  // Outputs watched
  input wire logic outer_loop_lock_flag,
  input wire logic outer_loop_lock_lost_flag,
  input wire logic holdover_active_reg,
  input wire logic hold_release_pulse_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire in_win = outer_pd_strobe && outer_edge_err <= outer_loop_window_width;
  ////////////////////////////////
  a_miss_drops_lock: assert property (
    outer_pd_strobe && !in_win |=> !outer_loop_lock_flag)
    else $error("Lock kept after window miss");
  a_idle_keeps_lock: assert property (
    !outer_pd_strobe |=> $stable(outer_loop_lock_flag))
    else $error("Lock moved without strobe");
  a_hit_keeps_lock: assert property (
    in_win && outer_loop_lock_flag |=> outer_loop_lock_flag)
    else $error("Lock lost on in-window strobe");
  a_fall_sets_lost: assert property (
    $fell(outer_loop_lock_flag) && !outer_loop_lost_clear
    |=> outer_loop_lock_lost_flag) else $error("Lost flag not set");
  a_lost_has_cause: assert property (
    $rose(outer_loop_lock_lost_flag) |-> $past(outer_loop_lock_flag, 2)
    && !$past(outer_loop_lock_flag)) else $error("Lost flag without fall");
  a_clear_holds_lost: assert property (
    outer_loop_lost_clear |=> !outer_loop_lock_lost_flag)
    else $error("Lost flag set during clear");
  a_exit_on_event: assert property (
    hold_release_pulse_reg && $past(holdover_active_reg) &&
    $past(hold_exit_on_lock) |-> !holdover_active_reg) else $error("No exit");
  a_hold_kept: assert property (
    holdover_active_reg && !hold_exit_on_lock |=> holdover_active_reg)
    else $error("Holdover left while exit off");
  c_lock: cover property ($rose(outer_loop_lock_flag));
  c_lost: cover property ($rose(outer_loop_lock_lost_flag));
  c_exit: cover property ($fell(holdover_active_reg));
endmodule // lkdet_chk
bind lkdet_top lkdet_chk chk (
  .clk(clk),
  .rstn(rstn),
  .outer_pd_strobe(outer_pd_strobe),
  .outer_edge_err(outer_edge_err),
  .outer_loop_window_width(outer_loop_window_width),
  .hold_exit_on_lock(hold_exit_on_lock),
  .outer_loop_lost_clear(outer_loop_lost_clear),
  .outer_loop_lock_flag(outer_loop_lock_flag),
  .outer_loop_lock_lost_flag(outer_loop_lock_lost_flag),
  .holdover_active_reg(holdover_active_reg),
  .hold_release_pulse_reg(hold_release_pulse_reg)
);
`default_nettype wire

// File: testbench/digital_lock_detect_tb_top.sv
// Self-checking testbench for the lock detector
`timescale 1ns/100ps
`default_nettype none
module digital_lock_detect_tb_top;
  logic clk = '0, rstn = '0, outer_pd_strobe = '0, inner_pd_strobe = '0;
  logic hold_exit_on_lock = '0, holdover_enter = '0;
  logic outer_loop_lost_clear = '0, inner_loop_lost_clear = '0;
  logic [7:0] outer_edge_err = '0, inner_edge_err = '0;
  logic [7:0] outer_loop_window_width = '0, inner_loop_window_width = '0;
  logic [13:0] outer_loop_lock_count = '0, inner_loop_lock_count = '0;
  logic [13:0] hold_release_lock_count = '0;
  wire outer_loop_lock_flag, inner_loop_lock_flag, holdover_active_reg;
  wire outer_loop_lock_lost_flag, inner_loop_lock_lost_flag;
  wire hold_release_pulse_reg;
  int n_errors = 0, comparisons = 0;
  always #2 clk = ~clk;
  lkdet_top dut (
    .clk(clk),
    .rstn(rstn),
    .outer_pd_strobe(outer_pd_strobe),
    .outer_edge_err(outer_edge_err),
    .inner_pd_strobe(inner_pd_strobe),
    .inner_edge_err(inner_edge_err),
    .outer_loop_window_width(outer_loop_window_width),
    .outer_loop_lock_count(outer_loop_lock_count),
    .inner_loop_window_width(inner_loop_window_width),
    .inner_loop_lock_count(inner_loop_lock_count),
    .hold_release_lock_count(hold_release_lock_count),
    .hold_exit_on_lock(hold_exit_on_lock),
    .holdover_enter(holdover_enter),
    .outer_loop_lost_clear(outer_loop_lost_clear),
    .inner_loop_lost_clear(inner_loop_lost_clear),
    .outer_loop_lock_flag(outer_loop_lock_flag),
    .inner_loop_lock_flag(inner_loop_lock_flag),
    .outer_loop_lock_lost_flag(outer_loop_lock_lost_flag),
    .inner_loop_lock_lost_flag(inner_loop_lock_lost_flag),
    .holdover_active_reg(holdover_active_reg),
    .hold_release_pulse_reg(hold_release_pulse_reg)
  );
  ////////////////////////////////
  task automatic chk(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rst;
    rstn = 1'h0;
    tick(2);
    rstn = 1'h1;
  endtask
  // Back-to-back strobes on one loop, same error each cycle
  task automatic burst(input logic inr, input int n, input logic [7:0] e);
    outer_pd_strobe = !inr;
    inner_pd_strobe = inr;
    outer_edge_err = e;
    inner_edge_err = e;
    tick(n);
    outer_pd_strobe = 1'h0;
    inner_pd_strobe = 1'h0;
  endtask
  task automatic t_outer;
    rst;
    outer_loop_window_width = 8'h10;
    outer_loop_lock_count = 14'h0003;
    inner_loop_lock_count = 14'h3FFF;
    burst(0, 2, 8'h10);
    chk(outer_loop_lock_flag, 1'h0);
    tick(1);
    burst(0, 1, 8'h05);
    chk(outer_loop_lock_flag, 1'h1);
    chk(inner_loop_lock_flag, 1'h0);
    tick(1);
    burst(0, 1, 8'h11);
    chk(outer_loop_lock_flag, 1'h0);
    tick(1);
    chk(outer_loop_lock_lost_flag, 1'h1);
    burst(0, 2, 8'h00);
    chk(outer_loop_lock_flag, 1'h0);
    outer_loop_lost_clear = 1'h1;
    tick(1);
    chk(outer_loop_lock_lost_flag, 1'h0);
    outer_loop_lost_clear = 1'h0;
    tick(2);
    chk(outer_loop_lock_lost_flag, 1'h0);
    $display("Test outer loop done");
  endtask
  task automatic t_inner;
    rst;
    inner_loop_window_width = 8'h02;
    inner_loop_lock_count = 14'h0002;
    burst(1, 2, 8'h02);
    chk(inner_loop_lock_flag, 1'h1);
    chk(outer_loop_lock_flag, 1'h0);
    tick(1);
    burst(1, 1, 8'h03);
    chk(inner_loop_lock_flag, 1'h0);
    inner_loop_lost_clear = 1'h1;
    tick(1);
    chk(inner_loop_lock_lost_flag, 1'h0);
    inner_loop_lost_clear = 1'h0;
    tick(2);
    chk(inner_loop_lock_lost_flag, 1'h0);
    burst(1, 2, 8'h00);
    chk(inner_loop_lock_flag, 1'h1);
    tick(1);
    burst(1, 1, 8'h03);
    tick(1);
    chk(inner_loop_lock_lost_flag, 1'h1);
    $display("Test inner loop done");
  endtask
  task automatic t_hold(input logic ex);
    rst;
    inner_loop_window_width = 8'h00;
    outer_loop_window_width = 8'h04;
    outer_loop_lock_count = 14'h07D0;
    hold_release_lock_count = 14'h0003;
    hold_exit_on_lock = ex;
    holdover_enter = 1'h1;
    tick(1);
    holdover_enter = 1'h0;
    burst(0, 3, 8'h04);
    chk(holdover_active_reg, 1'h1);
    tick(1);
    chk(holdover_active_reg, !ex);
    chk(outer_loop_lock_flag, 1'h0);
    chk(hold_release_pulse_reg, 1'h1);
    tick(1);
    chk(hold_release_pulse_reg, 1'h0);
    chk(holdover_active_reg, !ex);
    $display("Test holdover done");
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    t_outer;
    t_inner;
    t_hold(1'h1);
    t_hold(1'h0);
    print_verdict;
  end
  initial begin
    #20000;
    n_errors++;
    print_verdict;
  end
endmodule // digital_lock_detect_tb_top
`default_nettype wire
